// >>> design/rtc_alarm_pkg.sv
// constants, register map and types of the alarm and update interrupt block
// ============================================================
package rtc_alarm_pkg;

	// ============================================================
	// timing
	localparam int CLK_FREQ_HZ = 100_000_000;
	localparam int SECOND_S = 1;
	localparam int SECOND_CYCLES = SECOND_S * CLK_FREQ_HZ;
	localparam real IRQ_PULSE_MS = 7.8;
	// longest time, so rounded down
	localparam int IRQ_PULSE_CYCLES =
		int'($floor(IRQ_PULSE_MS * CLK_FREQ_HZ / 1000.0));

	// ============================================================
	// register indices (byte address is four times the index)
	localparam logic [5:0] IDX_SECOND = 6'h00;
	localparam logic [5:0] IDX_MINUTE = 6'h01;
	localparam logic [5:0] IDX_HOUR = 6'h02;
	localparam logic [5:0] IDX_WEEKDAY = 6'h03;
	localparam logic [5:0] IDX_DATE = 6'h04;
	localparam logic [5:0] IDX_ALARM_MINUTE = 6'h08;
	localparam logic [5:0] IDX_ALARM_HOUR = 6'h09;
	localparam logic [5:0] IDX_ALARM_DAY = 6'h0A;
	localparam logic [5:0] IDX_EXTENSION = 6'h0D;
	localparam logic [5:0] IDX_FLAGS = 6'h0E;
	localparam logic [5:0] IDX_CONTROL = 6'h0F;
	localparam logic [5:0] IDX_LINE_STATUS = 6'h10;

	// ============================================================
	// field positions
	localparam int EXT_TARGET_BIT = 6;
	localparam int EXT_UPDSEL_BIT = 5;
	localparam int FLAG_UPDATE_BIT = 5;
	localparam int FLAG_ALARM_BIT = 3;
	localparam int CTRL_UIE_BIT = 5;
	localparam int CTRL_AIE_BIT = 3;
	localparam int CTRL_RESET_BIT = 0;
	localparam int ALARM_MASK_BIT = 7;

	// ============================================================
	// readable bit masks; zero bits are write-protected
	localparam logic [7:0] SECOND_MASK = 8'h7F;
	localparam logic [7:0] MINUTE_MASK = 8'h7F;
	localparam logic [7:0] HOUR_MASK = 8'h3F;
	localparam logic [7:0] WEEKDAY_MASK = 8'h7F;
	localparam logic [7:0] DATE_MASK = 8'h3F;
	localparam logic [7:0] CONTROL_MASK = 8'hF9;

	// ============================================================
	// calendar limits and reset values
	localparam logic [7:0] SEC_LAST = 8'h59;
	localparam logic [7:0] MIN_LAST = 8'h59;
	localparam logic [7:0] HOUR_LAST = 8'h23;
	localparam logic [7:0] DATE_FIRST = 8'h01;
	localparam logic [7:0] DATE_LAST = 8'h31;
	localparam logic [7:0] WEEKDAY_FIRST = 8'h01;
	localparam logic [7:0] WEEKDAY_LAST = 8'h40;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [23:0] PAD_ZERO = 24'h000000;

	typedef struct packed {
		logic [7:0] second;
		logic [7:0] minute;
		logic [7:0] hour;
		logic [7:0] weekday;
		logic [7:0] date;
	} calendar_type;

	typedef struct packed {
		logic [7:0] minute;
		logic [7:0] hour;
		logic [7:0] day;
	} alarm_type;

endpackage

// >>> design/rtc_alarm_interrupt.sv
// alarm and time update interrupt logic with avalon-mm register slave
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module rtc_alarm_interrupt
	import rtc_alarm_pkg::*;
#(
	parameter int unsigned SECOND_TICKS = SECOND_CYCLES,
	parameter int unsigned PULSE_CYCLES = IRQ_PULSE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output var logic [31:0] readdata,
	output logic waitrequest,
	input wire logic irq_in,
	output logic irq_out,
	output logic irq_oe_n
);

	localparam int PW = $clog2(SECOND_TICKS);
	localparam int CW = $clog2(PULSE_CYCLES + 1);

	// ============================================================
	// bus slave
	logic ack_reg;
	logic [31:0] readdata_reg;
	logic [7:0] read_byte;
	logic [5:0] idx;
	logic wr_fire;

	calendar_type cal_reg;
	alarm_type alarm_reg;
	logic [7:0] ext_reg;
	logic [7:0] ctrl_reg;
	logic af_reg;
	logic uf_reg;
	logic irq_sync1_reg;
	logic irq_sync2_reg;

	assign idx = address[7:2];
	// one wait state: read data is fetched in the first cycle
	assign waitrequest = (read | write) & ~ack_reg;
	assign wr_fire = write & ack_reg & byteenable[0];
	assign readdata = readdata_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (read | write) & ~ack_reg;
		end
	end

	always_comb begin
		read_byte = BYTE_ZERO;
		case (idx)
			IDX_SECOND: read_byte = cal_reg.second & SECOND_MASK;
			IDX_MINUTE: read_byte = cal_reg.minute & MINUTE_MASK;
			IDX_HOUR: read_byte = cal_reg.hour & HOUR_MASK;
			IDX_WEEKDAY: read_byte = cal_reg.weekday & WEEKDAY_MASK;
			IDX_DATE: read_byte = cal_reg.date & DATE_MASK;
			IDX_ALARM_MINUTE: read_byte = alarm_reg.minute;
			IDX_ALARM_HOUR: read_byte = alarm_reg.hour;
			IDX_ALARM_DAY: read_byte = alarm_reg.day;
			IDX_EXTENSION: read_byte = ext_reg;
			IDX_FLAGS: begin
				read_byte[FLAG_UPDATE_BIT] = uf_reg;
				read_byte[FLAG_ALARM_BIT] = af_reg;
			end
			IDX_CONTROL: read_byte = ctrl_reg & CONTROL_MASK;
			IDX_LINE_STATUS: read_byte[0] = irq_sync2_reg;
			default: read_byte = BYTE_ZERO;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata_reg <= 32'h00000000;
		end else if (read && !ack_reg) begin
			readdata_reg <= {PAD_ZERO, read_byte};
		end
	end

	// ============================================================
	// time base and calendar counters
	logic [PW-1:0] presc_reg;
	logic sec_tick;
	logic min_tick;
	logic hour_tick;
	logic day_tick;
	logic reset_bit;

	assign reset_bit = ctrl_reg[CTRL_RESET_BIT];
	assign sec_tick = (presc_reg == PW'(SECOND_TICKS - 1)) & ~reset_bit;
	assign min_tick = sec_tick & (cal_reg.second == SEC_LAST);
	assign hour_tick = min_tick & (cal_reg.minute == MIN_LAST);
	assign day_tick = hour_tick & (cal_reg.hour == HOUR_LAST);

	function automatic logic [7:0] bcd_next(input logic [7:0] v,
		input logic [7:0] last, input logic [7:0] first);
		if (v == last) begin
			return first;
		end else if (v[3:0] == BCD_NINE) begin
			return {v[7:4] + 4'h1, 4'h0};
		end else begin
			return v + 8'h01;
		end
	endfunction

	// sub-second phase held at zero while the reset bit is set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_reg <= '0;
		end else if (reset_bit || sec_tick) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= PW'(presc_reg + 1'b1);
		end
	end

	// software writes win over a tick in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_reg.second <= BYTE_ZERO;
			cal_reg.minute <= BYTE_ZERO;
			cal_reg.hour <= BYTE_ZERO;
			cal_reg.weekday <= WEEKDAY_FIRST;
			cal_reg.date <= DATE_FIRST;
		end else begin
			if (wr_fire && idx == IDX_SECOND) begin
				cal_reg.second <= writedata[7:0] & SECOND_MASK;
			end else if (sec_tick) begin
				cal_reg.second <= bcd_next(cal_reg.second, SEC_LAST, BYTE_ZERO);
			end
			if (wr_fire && idx == IDX_MINUTE) begin
				cal_reg.minute <= writedata[7:0] & MINUTE_MASK;
			end else if (min_tick) begin
				cal_reg.minute <= bcd_next(cal_reg.minute, MIN_LAST, BYTE_ZERO);
			end
			if (wr_fire && idx == IDX_HOUR) begin
				cal_reg.hour <= writedata[7:0] & HOUR_MASK;
			end else if (hour_tick) begin
				cal_reg.hour <= bcd_next(cal_reg.hour, HOUR_LAST, BYTE_ZERO);
			end
			if (wr_fire && idx == IDX_WEEKDAY) begin
				cal_reg.weekday <= writedata[7:0] & WEEKDAY_MASK;
			end else if (day_tick) begin
				cal_reg.weekday <= (cal_reg.weekday == WEEKDAY_LAST) ?
					WEEKDAY_FIRST : {cal_reg.weekday[6:0], 1'b0};
			end
			// month length not modelled: date wraps after 31
			if (wr_fire && idx == IDX_DATE) begin
				cal_reg.date <= writedata[7:0] & DATE_MASK;
			end else if (day_tick) begin
				cal_reg.date <= bcd_next(cal_reg.date, DATE_LAST, DATE_FIRST);
			end
		end
	end

	// ============================================================
	// configuration registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_reg <= '0;
		end else if (wr_fire) begin
			// full bytes kept: spare bits are plain storage
			case (idx)
				IDX_ALARM_MINUTE: alarm_reg.minute <= writedata[7:0];
				IDX_ALARM_HOUR: alarm_reg.hour <= writedata[7:0];
				IDX_ALARM_DAY: alarm_reg.day <= writedata[7:0];
				default: alarm_reg <= alarm_reg;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_reg <= BYTE_ZERO;
		end else if (wr_fire && idx == IDX_EXTENSION) begin
			ext_reg <= writedata[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= BYTE_ZERO;
		end else if (wr_fire && idx == IDX_CONTROL) begin
			ctrl_reg <= writedata[7:0] & CONTROL_MASK;
		end
	end

	// ============================================================
	// alarm comparison
	logic minute_adv_reg;
	logic min_hit;
	logic hour_hit;
	logic day_hit;
	logic alarm_match;
	logic alarm_event;
	logic all_masked;

	// only counted advances arm the compare, never a register write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			minute_adv_reg <= 1'b0;
		end else begin
			minute_adv_reg <= min_tick;
		end
	end

	assign min_hit = alarm_reg.minute[ALARM_MASK_BIT] |
		(alarm_reg.minute[6:0] == cal_reg.minute[6:0]);
	assign hour_hit = alarm_reg.hour[ALARM_MASK_BIT] |
		(alarm_reg.hour[5:0] == cal_reg.hour[5:0]);
	assign day_hit = alarm_reg.day[ALARM_MASK_BIT] |
		(ext_reg[EXT_TARGET_BIT] ?
		(alarm_reg.day[5:0] == cal_reg.date[5:0]) :
		(|(alarm_reg.day[6:0] & cal_reg.weekday[6:0])));
	assign alarm_match = min_hit & hour_hit & day_hit;
	assign all_masked = alarm_reg.minute[ALARM_MASK_BIT] &
		alarm_reg.hour[ALARM_MASK_BIT] & alarm_reg.day[ALARM_MASK_BIT];
	assign alarm_event = minute_adv_reg & alarm_match & ~reset_bit;

	// ============================================================
	// event flags; a set in the clearing cycle wins
	logic af_clear;
	logic uf_clear;
	logic update_event;

	assign af_clear = wr_fire & (idx == IDX_FLAGS) & ~writedata[FLAG_ALARM_BIT];
	assign uf_clear = wr_fire & (idx == IDX_FLAGS) & ~writedata[FLAG_UPDATE_BIT];
	assign update_event = (ext_reg[EXT_UPDSEL_BIT] ? min_tick : sec_tick) &
		~reset_bit;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			af_reg <= 1'b0;
		end else if (alarm_event) begin
			af_reg <= 1'b1;
		end else if (af_clear) begin
			af_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			uf_reg <= 1'b0;
		end else if (update_event) begin
			uf_reg <= 1'b1;
		end else if (uf_clear) begin
			uf_reg <= 1'b0;
		end
	end

	// ============================================================
	// update pulse and shared line
	logic update_low_reg;
	logic [CW-1:0] update_cnt_reg;
	logic update_irq_enable;
	logic alarm_irq_enable;
	logic update_req;
	logic alarm_req;
	logic line_req;
	logic irq_oe_n_reg;

	assign update_irq_enable = ctrl_reg[CTRL_UIE_BIT];
	assign alarm_irq_enable = ctrl_reg[CTRL_AIE_BIT];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			update_low_reg <= 1'b0;
			update_cnt_reg <= '0;
		end else if (update_event && update_irq_enable) begin
			update_low_reg <= 1'b1;
			update_cnt_reg <= '0;
		end else if (update_low_reg &&
			(update_cnt_reg == CW'(PULSE_CYCLES - 1) || !update_irq_enable)) begin
			update_low_reg <= 1'b0;
		end else if (update_low_reg) begin
			update_cnt_reg <= CW'(update_cnt_reg + 1'b1);
		end
	end

	assign update_req = update_low_reg & update_irq_enable;
	assign alarm_req = af_reg & alarm_irq_enable;
	assign line_req = update_req | alarm_req;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_oe_n_reg <= 1'b1;
		end else begin
			irq_oe_n_reg <= ~line_req;
		end
	end

	// line level readback; first stage feeds only the second
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_sync1_reg <= 1'b1;
			irq_sync2_reg <= 1'b1;
		end else begin
			irq_sync1_reg <= irq_in;
			irq_sync2_reg <= irq_sync1_reg;
		end
	end

	assign irq_out = 1'b0;
	assign irq_oe_n = irq_oe_n_reg;

	// ============================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_update_start;
		update_event && update_irq_enable;
	endsequence

	sequence s_alarm_armed;
		minute_adv_reg && alarm_match && !reset_bit;
	endsequence

	a_update_pulse_low: assert property (
		s_update_start |=> (update_low_reg and (update_irq_enable |=> !irq_oe_n)))
		else $error("update event did not pull the line low");

	a_update_self_release: assert property (
		(update_low_reg && update_cnt_reg == CW'(PULSE_CYCLES - 1) &&
		!update_event) |=> !update_low_reg)
		else $error("update pulse outlived its length");

	a_update_gated: assert property (
		(!update_irq_enable && !alarm_req) |=> irq_oe_n)
		else $error("line low with update enable cleared and no alarm");

	a_line_shared: assert property (
		(line_req && !update_req) |=> !irq_oe_n)
		else $error("disabled source released a line still requested");

	a_alarm_on_match: assert property (
		s_alarm_armed |=> af_reg)
		else $error("matching alarm did not set the flag");

	a_alarm_on_advance: assert property (
		$rose(af_reg) |-> $past(minute_adv_reg))
		else $error("alarm flag rose without a counter advance");

	a_flag_sticky: assert property (
		(af_reg && !af_clear) |=> af_reg)
		else $error("alarm flag dropped without a zero write");

	a_alarm_holds: assert property (
		alarm_req |=> !irq_oe_n)
		else $error("alarm request did not hold the line low");

	a_aie_release: assert property (
		($fell(alarm_irq_enable) && !update_req) |=> irq_oe_n)
		else $error("line not released when alarm enable cleared");

	a_af_release: assert property (
		($fell(af_reg) && !update_req) |=> irq_oe_n)
		else $error("line not released when alarm flag cleared");

	a_alarm_disabled: assert property (
		(alarm_event && !alarm_irq_enable) |=> af_reg && !alarm_req)
		else $error("disabled alarm drove the line");

	a_reset_blocks: assert property (
		reset_bit |=> $stable(af_reg) || !af_reg)
		else $error("alarm raised while reset bit set");

	a_every_minute: assert property (
		(minute_adv_reg && all_masked && !reset_bit) |-> alarm_event)
		else $error("fully masked alarm missed a minute");

	a_one_write_noop: assert property (
		(wr_fire && idx == IDX_FLAGS && writedata[FLAG_ALARM_BIT] &&
		!af_reg && !alarm_event) |=> !af_reg)
		else $error("writing one changed the alarm flag");

	a_bus_one_wait: assert property (
		((read || write) && waitrequest) |=> !waitrequest)
		else $error("slave held waitrequest beyond one cycle");

endmodule
`default_nettype wire

// >>> test/irq_wire_model.sv
// shared open-drain interrupt wire with pull-up and one more source
`timescale 1ns/1ns
`default_nettype none
module irq_wire_model (
	input wire logic dut_out,
	input wire logic dut_oe_n,
	input wire logic other_pull,
	output logic line
);
	// pull-up level unless some party pulls the wire low
	assign line = (dut_oe_n ? 1'b1 : dut_out) & ~other_pull;
endmodule
`default_nettype wire

// >>> test/tb_rtc_alarm_interrupt.sv
// self-checking bench of the alarm and update interrupt block
`timescale 1ns/1ns
`default_nettype none
module tb_rtc_alarm_interrupt
	import rtc_alarm_pkg::*;
;
	localparam int TK = 20;
	localparam int PC = 8;
	logic core_clk, rst_n, read, write, irq_out, irq_oe_n;
	logic waitrequest, line, other_pull;
	logic [7:0] address, q;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable;
	logic [31:0] seed = 32'h00000050;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;

	rtc_alarm_interrupt #(.SECOND_TICKS(TK), .PULSE_CYCLES(PC)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .irq_in(line), .irq_out(irq_out),
		.irq_oe_n(irq_oe_n)
	);
	irq_wire_model u_wire (
		.dut_out(irq_out), .dut_oe_n(irq_oe_n),
		.other_pull(other_pull), .line(line)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			end_of_test();
		end
	end

	// ============================================================
	// bus and checking helpers
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// request held up to the edge at which waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] i,
		input logic [7:0] d);
		@(posedge core_clk);
		address <= {i, 2'h0};
		writedata <= {24'h000000, d};
		write <= wr;
		read <= ~wr;
		@(posedge core_clk);
		while (waitrequest !== 1'b0)
			@(posedge core_clk);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask

	task automatic rd(input logic [5:0] i);
		bus(1'b0, i, 8'h00);
	endtask

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_line(input logic exp);
		// look half a cycle on, once the edge's updates have settled
		@(negedge core_clk);
		tests_run++;
		if (irq_oe_n !== exp || irq_out !== 1'b0) begin
			fail_count++;
			$display("[FAIL] %0t line enable expected %b", $time, exp);
		end
	endtask

	task automatic settle();
		@(posedge core_clk);
		@(negedge core_clk);
	endtask

	// counts pull-down starts and the longest low run
	task automatic watch(input int cycles, output int falls, output int run);
		logic prev;
		int len;
		prev = irq_oe_n;
		falls = 0;
		run = 0;
		len = 0;
		repeat (cycles) begin
			@(negedge core_clk);
			if (prev && !irq_oe_n)
				falls++;
			len = irq_oe_n ? 0 : len + 1;
			if (len > run)
				run = len;
			prev = irq_oe_n;
		end
	endtask

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic hit_of(input logic [7:0] am, ah, ad, ex,
		mn, hr, wd, dt);
		logic m, h, d;
		m = am[7] | (am[6:0] == mn[6:0]);
		h = ah[7] | (ah[5:0] == hr[5:0]);
		d = ad[7] | (ex[6] ? ad[5:0] == dt[5:0] : |(ad[6:0] & wd[6:0]));
		return m & h & d;
	endfunction

	// ============================================================
	// main sequence
	initial begin
		int f, r, n;
		logic [7:0] am, ah, ad, ex, ct, mn, nx, hr, wd, dt;
		logic hit;
		logic [31:0] v, w;
		rst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h00000000;
		byteenable = 4'hF;
		other_pull = 1'b0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(IDX_CONTROL);
		cmp(q, 8'h00);
		cmp_line(1'b1);
		for (int i = 0; i < 3; i++) begin
			v = xs();
			wr(IDX_ALARM_MINUTE + 6'(i), v[7:0]);
			rd(IDX_ALARM_MINUTE + 6'(i));
			cmp(q, v[7:0]);
		end
		byteenable <= 4'hE;
		wr(IDX_ALARM_DAY, ~v[7:0]);
		byteenable <= 4'hF;
		rd(IDX_ALARM_DAY);
		cmp(q, v[7:0]);
		wr(IDX_CONTROL, 8'hFF);
		rd(IDX_CONTROL);
		cmp(q, 8'hF9);
		wr(IDX_CONTROL, 8'h00);
		rd(6'h3F);
		cmp(q, 8'h00);
		other_pull <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(IDX_LINE_STATUS);
		cmp(q, 8'h00);
		cmp_line(1'b1);
		other_pull <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd(IDX_LINE_STATUS);
		cmp(q, 8'h01);
		// update pulses: once a second or once a minute, self-releasing
		wr(IDX_EXTENSION, 8'h00);
		wr(IDX_CONTROL, 8'h20);
		watch(10 * TK, f, r);
		cmp(8'(f), 8'h0A);
		cmp(8'(r > 0 && r <= PC + 1), 8'h01);
		rd(IDX_FLAGS);
		cmp(q & 8'h20, 8'h20);
		n = 0;
		while (irq_oe_n !== 1'b0 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		wr(IDX_CONTROL, 8'h00);
		settle();
		cmp_line(1'b1);
		watch(10 * TK, f, r);
		cmp(8'(f), 8'h00);
		wr(IDX_EXTENSION, 8'h20);
		wr(IDX_CONTROL, 8'h20);
		watch(60 * TK, f, r);
		cmp(8'(f), 8'h01);
		// alarm matches with random fields and corner cases
		for (int i = 0; i < 12; i++) begin
			v = xs();
			w = xs();
			mn = {1'b0, 3'(v[2:0] % 6), 4'(v[6:3] % 9)};
			nx = mn + 8'h01;
			hr = {3'h0, v[11], 4'(v[15:12] % 10)};
			wd = 8'h01 << (v[18:16] % 7);
			dt = 8'h01 + 8'(v[22:19] % 9);
			ex = {1'b0, w[6], 6'h00};
			am = w[1:0] == 0 ? nx ^ 8'h02 : (w[0] ? nx : {1'b1, w[14:8]});
			ah = w[3:2] == 0 ? hr ^ 8'h01 : (w[2] ? hr : {1'b1, w[22:16]});
			ad = w[4] ? {1'b1, w[30:24]} : {1'b0, w[30:24]};
			if (w[5])
				ad = ex[6] ? dt : wd;
			ct = (w[7] && i > 3) ? 8'h00 : 8'h08;
			if (i == 0) begin
				am = 8'h80;
				ah = 8'h80;
				ad = 8'h80;
			end
			if (i == 1)
				ct = 8'h09;
			if (i == 2) begin
				ex = 8'h00;
				ad = 8'h7F & ~wd;
			end
			hit = ~ct[0] & hit_of(am, ah, ad, ex, nx, hr, wd, dt);
			wr(IDX_CONTROL, 8'h00);
			// second cleared first so no minute rolls mid-setup
			wr(IDX_SECOND, 8'h00);
			wr(IDX_FLAGS, 8'h00);
			wr(IDX_EXTENSION, ex);
			wr(IDX_ALARM_MINUTE, am);
			wr(IDX_ALARM_HOUR, ah);
			wr(IDX_ALARM_DAY, ad);
			wr(IDX_HOUR, hr);
			wr(IDX_WEEKDAY, wd);
			wr(IDX_DATE, dt);
			wr(IDX_MINUTE, mn);
			// control first: a tick right after the second write cannot
			// slip in ahead of the new enable or reset bit
			wr(IDX_CONTROL, ct);
			wr(IDX_SECOND, 8'h59);
			repeat (TK + 6) @(posedge core_clk);
			rd(IDX_FLAGS);
			cmp(q & 8'h08, {4'h0, hit, 3'h0});
			cmp_line(~(hit & ct[3]));
			if (hit & ct[3]) begin
				repeat (PC + 4) @(posedge core_clk);
				cmp_line(1'b0);
				wr(IDX_FLAGS, 8'hFF);
				settle();
				cmp_line(1'b0);
				wr(IDX_CONTROL, 8'h28);
				wr(IDX_CONTROL, 8'h08);
				settle();
				cmp_line(1'b0);
				if (i % 2)
					wr(IDX_FLAGS, 8'h00);
				else
					wr(IDX_CONTROL, 8'h00);
				settle();
				cmp_line(1'b1);
			end
		end
		// alarm written equal to the present minute stays quiet
		wr(IDX_CONTROL, 8'h00);
		wr(IDX_SECOND, 8'h00);
		wr(IDX_FLAGS, 8'h00);
		wr(IDX_ALARM_MINUTE, 8'h30);
		wr(IDX_ALARM_HOUR, 8'h80);
		wr(IDX_ALARM_DAY, 8'h80);
		wr(IDX_MINUTE, 8'h30);
		repeat (3 * TK) @(posedge core_clk);
		rd(IDX_FLAGS);
		cmp(q & 8'h08, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
